//--- logic/gpib_status_pkg.sv
package gpib_status_pkg;
    // ***********************************
    // Register map (APB byte addresses)
    // ***********************************
    localparam logic [7:0] OFF_ADDR = 8'h00;
    localparam logic [7:0] OFF_STATE = 8'h04;
    localparam logic [7:0] OFF_ESR = 8'h08;
    localparam logic [7:0] OFF_ESE = 8'h0c;
    localparam logic [7:0] OFF_OPCOND = 8'h10;
    localparam logic [7:0] OFF_OPEVT = 8'h14;
    localparam logic [7:0] OFF_OPENA = 8'h18;
    localparam logic [7:0] OFF_STB = 8'h1c;
    localparam logic [7:0] OFF_SRE = 8'h20;
    localparam logic [7:0] OFF_CMD = 8'h24;
    localparam logic [7:0] OFF_RESP = 8'h28;

    // ***********************************
    // Reset values
    // ***********************************
    localparam logic [4:0] ADDR_RESET = 5'h01;
    localparam logic [7:0] ESR_RESET = 8'h80;
    localparam logic [7:0] ENA_RESET = 8'h00;

    // ***********************************
    // Field positions
    // ***********************************
    localparam int ESR_PON = 7;
    localparam int ESR_CME = 5;
    localparam int ESR_EXE = 4;
    localparam int ESR_QYE = 2;
    localparam int ESR_OPC = 0;
    localparam int STB_OSB = 7;
    localparam int STB_MSS = 6;
    localparam int STB_ESB = 5;
    localparam int CMDB_CLS = 0;
    localparam int CMDB_OPC = 1;
    localparam int CMDB_CME = 2;
    localparam int CMDB_EXE = 3;
    localparam int CMDB_QYE = 4;

    // ***********************************
    // Multiline interface messages
    // ***********************************
    localparam logic [7:0] MSG_GTL = 8'h01;
    localparam logic [7:0] MSG_SDC = 8'h04;
    localparam logic [7:0] MSG_LLO = 8'h11;
    localparam logic [7:0] MSG_DCL = 8'h14;
    localparam logic [7:0] MSG_SPE = 8'h18;
    localparam logic [7:0] MSG_SPD = 8'h19;
    localparam logic [7:0] MSG_UNL = 8'h3f;
    localparam logic [7:0] MSG_UNT = 8'h5f;
    localparam logic [2:0] GRP_LISTEN = 3'h1;
    localparam logic [2:0] GRP_TALK = 3'h2;

    // Interface state as seen by software
    typedef struct packed {
        logic respPending;
        logic serialPoll;
        logic talker;
        logic listener;
        logic lockout;
        logic remote;
    } ifState_t;

    typedef enum {TX_IDLE, TX_RESP, TX_POLL} txState_t;
endpackage

//--- logic/pin_sync.sv
// Three-stage synchroniser; the output moves once stages two and three agree
module pin_sync
    import gpib_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Shift chain
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Accept a new level only when it is stable
    always_ff @(posedge clk) begin
        if (rst) begin
            level <= 1'b0;
        end else if (s2_r == s3_r) begin
            level <= s3_r;
        end
    end
endmodule

//--- logic/event_latch.sv
// Sticky event bits; a set in the clearing cycle wins
module event_latch
    import gpib_status_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] setBits,
    input wire logic clear,
    output logic [7:0] events
);
    // Latch events, ignore repeats until cleared
    always_ff @(posedge clk) begin
        if (rst) begin
            events <= RESET_VAL;
        end else if (clear) begin
            events <= setBits;
        end else begin
            events <= events | setBits;
        end
    end
endmodule

//--- logic/gpib_remote_status.sv
module gpib_remote_status
    import gpib_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic renPin_n,
    input wire logic ifcPin_n,
    input wire logic atnPin_n,
    input wire logic keyPin,
    input wire logic [7:0] busByte,
    input wire logic busByteValid,
    input wire logic [7:0] opCondition,
    input wire logic talkReady,
    output logic [7:0] talkData,
    output logic talkValid,
    output logic srqDrive,
    output logic remoteLed,
    output logic keypadEnable
);
    // ***********************************
    // Pin synchronisers
    // ***********************************
    logic renLow;
    logic ifcLow;
    logic atnLow;
    logic keyLevel;
    pin_sync uRen (.clk(clk), .rst(rst), .pin(~renPin_n), .level(renLow));
    pin_sync uIfc (.clk(clk), .rst(rst), .pin(~ifcPin_n), .level(ifcLow));
    pin_sync uAtn (.clk(clk), .rst(rst), .pin(~atnPin_n), .level(atnLow));
    pin_sync uKey (.clk(clk), .rst(rst), .pin(keyPin), .level(keyLevel));

    logic renPrev_r;
    logic keyPrev_r;
    logic renRise;
    logic renFall;
    logic keyEdge;

    // Edge history of the clean levels
    always_ff @(posedge clk) begin
        if (rst) begin
            renPrev_r <= 1'b0;
            keyPrev_r <= 1'b0;
        end else begin
            renPrev_r <= renLow;
            keyPrev_r <= keyLevel;
        end
    end
    assign renRise = renLow && !renPrev_r;
    assign renFall = !renLow && renPrev_r;
    assign keyEdge = keyLevel && !keyPrev_r;

    // ***********************************
    // Multiline command decode
    // ***********************************
    ifState_t st_r;
    logic [4:0] addr_r;
    logic cmdValid;
    logic lloHit;
    logic dclHit;
    logic sdcHit;
    logic gtlHit;
    logic speHit;
    logic spdHit;
    logic mlaHit;
    logic mtaHit;
    logic clearHit;

    assign cmdValid = busByteValid && atnLow;
    assign lloHit = cmdValid && busByte == MSG_LLO;
    assign dclHit = cmdValid && busByte == MSG_DCL;
    assign speHit = cmdValid && busByte == MSG_SPE;
    assign spdHit = cmdValid && busByte == MSG_SPD;
    assign sdcHit = cmdValid && st_r.listener && busByte == MSG_SDC;
    assign gtlHit = cmdValid && st_r.listener && busByte == MSG_GTL;
    assign mlaHit = cmdValid && busByte == {GRP_LISTEN, addr_r};
    assign mtaHit = cmdValid && busByte == {GRP_TALK, addr_r};
    assign clearHit = dclHit || sdcHit;

    // ***********************************
    // APB slave
    // ***********************************
    logic setupPh;
    logic accessDone;
    logic wrDone;
    logic rdDone;
    logic mapped;
    logic [7:0] esr;
    logic [7:0] opEvt;
    logic [7:0] ese_r;
    logic [7:0] opEna_r;
    logic [7:0] sre_r;
    logic [7:0] stb;
    logic [7:0] resp_r;
    logic esrSummary;
    logic opSummary;
    logic mss;
    logic [31:0] rdMux;

    assign setupPh = psel && !penable;
    assign accessDone = psel && penable && pready;
    assign wrDone = accessDone && pwrite;
    assign rdDone = accessDone && !pwrite;

    // Decode of the mapped offsets
    always_comb begin
        case (paddr)
            OFF_ADDR, OFF_STATE, OFF_ESR, OFF_ESE, OFF_OPCOND, OFF_OPEVT,
            OFF_OPENA, OFF_STB, OFF_SRE, OFF_CMD, OFF_RESP: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Read data selection
    always_comb begin
        rdMux = 32'h0;
        case (paddr)
            OFF_ADDR: rdMux[4:0] = addr_r;
            OFF_STATE: rdMux[5:0] = st_r;
            OFF_ESR: rdMux[7:0] = esr;
            OFF_ESE: rdMux[7:0] = ese_r;
            OFF_OPCOND: rdMux[7:0] = opCondition;
            OFF_OPEVT: rdMux[7:0] = opEvt;
            OFF_OPENA: rdMux[7:0] = opEna_r;
            OFF_STB: rdMux[7:0] = stb;
            OFF_SRE: rdMux[7:0] = sre_r;
            default: rdMux = 32'h0;
        endcase
    end

    // No wait states: ready in the first access cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setupPh;
            pslverr <= setupPh && !mapped;
            prdata <= (setupPh && !pwrite) ? rdMux : 32'h0;
        end
    end

    // Writable configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_r <= ADDR_RESET;
            ese_r <= ENA_RESET;
            opEna_r <= ENA_RESET;
            sre_r <= ENA_RESET;
        end else if (wrDone) begin
            case (paddr)
                OFF_ADDR: addr_r <= pwdata[4:0];
                OFF_ESE: ese_r <= pwdata[7:0];
                OFF_OPENA: opEna_r <= pwdata[7:0];
                OFF_SRE: sre_r <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ***********************************
    // Status system
    // ***********************************
    logic clsHit;
    logic esrRead;
    logic [7:0] esrSet;
    logic [7:0] opSet;
    logic [7:0] opCondPrev_r;

    assign clsHit = wrDone && paddr == OFF_CMD && pwdata[CMDB_CLS];
    assign esrRead = rdDone && paddr == OFF_ESR;

    // Firmware reported events land on their fixed bits
    always_comb begin
        esrSet = 8'h0;
        if (wrDone && paddr == OFF_CMD) begin
            esrSet[ESR_OPC] = pwdata[CMDB_OPC];
            esrSet[ESR_CME] = pwdata[CMDB_CME];
            esrSet[ESR_EXE] = pwdata[CMDB_EXE];
            esrSet[ESR_QYE] = pwdata[CMDB_QYE];
        end
    end

    // Operation events fire on rising condition bits
    always_ff @(posedge clk) begin
        if (rst) begin
            opCondPrev_r <= 8'h0;
        end else begin
            opCondPrev_r <= opCondition;
        end
    end
    assign opSet = opCondition & ~opCondPrev_r;

    // Power-on bit starts set
    event_latch #(.RESET_VAL(ESR_RESET)) uEsr (
        .clk(clk), .rst(rst), .setBits(esrSet),
        .clear(esrRead || clsHit), .events(esr));
    event_latch #(.RESET_VAL(ENA_RESET)) uOpEvt (
        .clk(clk), .rst(rst), .setBits(opSet),
        .clear(clsHit), .events(opEvt));

    // Summaries and the live status byte
    assign esrSummary = |(esr & ese_r);
    assign opSummary = |(opEvt & opEna_r);
    always_comb begin
        stb = 8'h0;
        stb[STB_ESB] = esrSummary;
        stb[STB_OSB] = opSummary;
        stb[STB_MSS] = mss;
    end
    // Built from the summaries alone so the status byte has no loop through its own bit 6
    assign mss = (opSummary && sre_r[STB_OSB]) || (esrSummary && sre_r[STB_ESB]);

    // Service request line
    always_ff @(posedge clk) begin
        if (rst) begin
            srqDrive <= 1'b0;
        end else begin
            srqDrive <= mss;
        end
    end

    // ***********************************
    // Remote/local and lockout
    // ***********************************
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r.remote <= 1'b0;
        end else if (renFall) begin
            st_r.remote <= 1'b0;
        end else if (renRise) begin
            st_r.remote <= 1'b1;
        end else if (gtlHit) begin
            st_r.remote <= 1'b0;
        end else if (keyEdge && !st_r.lockout) begin
            st_r.remote <= ~st_r.remote;
        end
    end

    // Lockout holds until REN is released
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r.lockout <= 1'b0;
        end else if (renFall) begin
            st_r.lockout <= 1'b0;
        end else if (lloHit) begin
            st_r.lockout <= 1'b1;
        end
    end

    // Panel indicator and keypad gate
    always_ff @(posedge clk) begin
        if (rst) begin
            remoteLed <= 1'b0;
            keypadEnable <= 1'b1;
        end else begin
            remoteLed <= st_r.remote;
            keypadEnable <= !st_r.remote && !st_r.lockout;
        end
    end

    // ***********************************
    // Addressing and serial poll
    // ***********************************
    always_ff @(posedge clk) begin
        if (rst || ifcLow) begin
            st_r.listener <= 1'b0;
            st_r.talker <= 1'b0;
        end else if (mlaHit) begin
            st_r.listener <= 1'b1;
            st_r.talker <= 1'b0;
        end else if (mtaHit) begin
            st_r.talker <= 1'b1;
            st_r.listener <= 1'b0;
        end else if (cmdValid && busByte == MSG_UNL) begin
            st_r.listener <= 1'b0;
        end else if (cmdValid && busByte == MSG_UNT) begin
            st_r.talker <= 1'b0;
        end
    end

    logic pollSent_r;
    always_ff @(posedge clk) begin
        if (rst || ifcLow || spdHit) begin
            st_r.serialPoll <= 1'b0;
        end else if (speHit) begin
            st_r.serialPoll <= 1'b1;
        end
    end

    // ***********************************
    // Talker: responses and poll byte
    // ***********************************
    txState_t tx_r;
    logic abort;
    logic respWr;
    logic taken;

    assign abort = ifcLow || clearHit;
    assign respWr = wrDone && paddr == OFF_RESP;
    assign taken = talkValid && talkReady;

    // Pending response; a newer query replaces it
    always_ff @(posedge clk) begin
        if (rst || abort) begin
            st_r.respPending <= 1'b0;
            resp_r <= 8'h0;
        end else if (respWr) begin
            st_r.respPending <= 1'b1;
            resp_r <= pwdata[7:0];
        end else if (taken && tx_r == TX_RESP) begin
            st_r.respPending <= 1'b0;
        end
    end

    // Poll byte goes out once per poll session
    always_ff @(posedge clk) begin
        if (rst || speHit || spdHit || abort) begin
            pollSent_r <= 1'b0;
        end else if (taken && tx_r == TX_POLL) begin
            pollSent_r <= 1'b1;
        end
    end

    // Talker state machine
    always_ff @(posedge clk) begin
        if (rst || abort) begin
            tx_r <= TX_IDLE;
            talkValid <= 1'b0;
            talkData <= 8'h0;
        end else begin
            case (tx_r)
                TX_IDLE: begin
                    if (st_r.talker && st_r.serialPoll && !pollSent_r) begin
                        tx_r <= TX_POLL;
                        talkValid <= 1'b1;
                        talkData <= stb;
                    end else if (st_r.talker && !st_r.serialPoll && st_r.respPending) begin
                        tx_r <= TX_RESP;
                        talkValid <= 1'b1;
                        talkData <= resp_r;
                    end
                end
                TX_RESP: begin
                    if (respWr) begin
                        talkData <= pwdata[7:0];
                    end else if (taken) begin
                        tx_r <= TX_IDLE;
                        talkValid <= 1'b0;
                    end
                end
                TX_POLL: begin
                    if (taken) begin
                        tx_r <= TX_IDLE;
                        talkValid <= 1'b0;
                    end
                end
                default: begin
                    tx_r <= TX_IDLE;
                    talkValid <= 1'b0;
                end
            endcase
        end
    end

    // ***********************************
    // Assertions
    // ***********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence pollReady;
        tx_r == TX_IDLE && st_r.talker && st_r.serialPoll && !pollSent_r && !abort;
    endsequence
    sequence pollPresented;
        talkValid && talkData == $past(stb) && tx_r == TX_POLL;
    endsequence

    a_key_toggle:
        assert property (keyEdge && !renRise && !renFall && !gtlHit && !st_r.lockout
            |=> st_r.remote != $past(st_r.remote))
        else $error("key press did not toggle remote state");
    a_remote_panel:
        assert property (st_r.remote |=> remoteLed && !keypadEnable)
        else $error("remote state without indicator or with keypad live");
    a_ren_remote:
        assert property (renRise |=> st_r.remote)
        else $error("REN did not enter remote");
    a_ifc_abort:
        assert property (ifcLow |=> !talkValid && !st_r.talker && !st_r.listener)
        else $error("IFC left a transfer active");
    a_llo_lock:
        assert property (lloHit && !renFall |=> st_r.lockout ##1 !keypadEnable)
        else $error("LLO did not lock the panel");
    a_dcl_idle:
        assert property (dclHit |=> !talkValid && !st_r.respPending && tx_r == TX_IDLE)
        else $error("DCL did not idle the interface");
    a_sdc_addressed:
        assert property (cmdValid && busByte == MSG_SDC && !st_r.listener && st_r.respPending
            && !taken && !respWr && !ifcLow |=> st_r.respPending)
        else $error("SDC acted without listen address");
    a_gtl_local:
        assert property (gtlHit && !renRise |=> !st_r.remote)
        else $error("GTL did not return to local");
    a_poll_byte:
        assert property (pollReady |=> pollPresented)
        else $error("serial poll did not present status byte");
    a_resp_talker:
        assert property (!st_r.talker && tx_r == TX_IDLE |=> !talkValid)
        else $error("response sent while not talk addressed");
    a_esr_sticky:
        assert property (!esrRead && !clsHit |=> (esr & $past(esr)) == $past(esr))
        else $error("event bit dropped without a clear");
    a_esr_readclr:
        assert property (esrRead && esrSet == 8'h0 |=> esr == 8'h0 && !stb[STB_ESB])
        else $error("reading ESR did not clear it");
    a_srq_mss:
        assert property ((stb[STB_OSB] && sre_r[STB_OSB]) || (stb[STB_ESB] && sre_r[STB_ESB]) |=> srqDrive)
        else $error("enabled summary did not raise SRQ");
endmodule

//--- sim/gpib_ctrl_model.sv
// Bus controller seen from the instrument: uniline pins, command bytes, talker acceptor
module gpib_ctrl_model (
    input wire logic clk,
    output logic renPin_n,
    output logic ifcPin_n,
    output logic atnPin_n,
    output logic [7:0] busByte,
    output logic busByteValid,
    output logic talkReady,
    input wire logic [7:0] talkData,
    input wire logic talkValid
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus: all lines released
    initial begin
        renPin_n = 1'b1;
        ifcPin_n = 1'b1;
        atnPin_n = 1'b1;
        busByte = 8'h00;
        busByteValid = 1'b0;
        talkReady = 1'b0;
    end

    // One byte; interface messages travel with ATN low, data with ATN high
    task automatic send(input logic [7:0] b, input logic cmd);
        atnPin_n <= ~cmd;
        repeat (5) @(posedge clk);
        busByte <= b;
        busByteValid <= 1'b1;
        @(posedge clk);
        busByteValid <= 1'b0;
        busByte <= ~b; // Released lines must not keep the last byte
        repeat (4) @(posedge clk);
    endtask

    // Uniline levels, held long enough to pass the pin synchronisers
    task automatic pin(input logic ren, input logic ifc);
        renPin_n <= ~ren;
        ifcPin_n <= ~ifc;
        repeat (8) @(posedge clk);
    endtask

    // Chained message string, length capped, ending in a terminator
    task automatic sendText(input string s);
        if (s.len() > 255) s = s.substr(0, 254);
        for (int i = 0; i < s.len(); i++) send(s[i], 1'b0);
        send(8'h0a, 1'b0);
    endtask

    // Accepts one talker byte; unknown if none is offered in time
    task automatic take(output logic [7:0] d);
        int n;
        d = 8'hxx;
        n = 0;
        talkReady <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (talkValid !== 1'b1 && n < 40);
        if (talkValid === 1'b1) d = talkData;
        talkReady <= 1'b0;
        @(posedge clk);
    endtask
endmodule

//--- sim/tb_gpib_remote_status_reporting.sv
module tb_gpib_remote_status_reporting import gpib_status_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ***********************************
    // Signals and instances
    // ***********************************
    localparam logic [7:0] talkAddr = {GRP_TALK, ADDR_RESET};
    localparam logic [7:0] listenAddr = {GRP_LISTEN, ADDR_RESET};
    logic clk, rst, psel, penable, pwrite, keyPin, pready, pslverr, e;
    logic renPin_n, ifcPin_n, atnPin_n, busByteValid, talkReady, talkValid, srqDrive, remoteLed, keypadEnable;
    logic [7:0] paddr, opCondition, busByte, talkData, got;
    logic [31:0] pwdata, prdata, r;
    int cb[4] = '{CMDB_OPC, CMDB_CME, CMDB_EXE, CMDB_QYE};
    int eb[4] = '{ESR_OPC, ESR_CME, ESR_EXE, ESR_QYE};
    int error_cnt = 0;
    int cmp_count = 0;
    int cycles = 0;

    gpib_remote_status dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .renPin_n(renPin_n), .ifcPin_n(ifcPin_n), .atnPin_n(atnPin_n), .keyPin(keyPin),
        .busByte(busByte), .busByteValid(busByteValid), .opCondition(opCondition),
        .talkReady(talkReady), .talkData(talkData), .talkValid(talkValid), .srqDrive(srqDrive),
        .remoteLed(remoteLed), .keypadEnable(keypadEnable));

    gpib_ctrl_model ctl (.clk(clk), .renPin_n(renPin_n), .ifcPin_n(ifcPin_n), .atnPin_n(atnPin_n),
        .busByte(busByte), .busByteValid(busByteValid), .talkReady(talkReady),
        .talkData(talkData), .talkValid(talkValid));

    // Clock generator
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    // ***********************************
    // Access and compare tasks
    // ***********************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] act);
        cmp_count++;
        if (act !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, act);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rv, output logic ev);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rv = prdata;
        ev = pslverr;
        chk("pready", 32'h1, {31'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, r, e);
        chk($sformatf("register %h", a), exp, r);
    endtask

    // Panel outputs as {remoteLed, keypadEnable, srqDrive}
    task automatic outs(input logic [2:0] exp);
        chk("led keypad srq", {29'h0, exp}, {29'h0, remoteLed, keypadEnable, srqDrive});
    endtask

    task automatic tv(input logic exp);
        chk("talkValid", {31'h0, exp}, {31'h0, talkValid});
    endtask

    task automatic press;
        keyPin <= 1'b1;
        repeat (6) @(posedge clk);
        keyPin <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ***********************************
    // Test sequence
    // ***********************************
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        keyPin = 1'b0;
        opCondition = 8'h00;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        outs(3'b010);
        rd(OFF_ADDR, 32'h1);
        rd(OFF_ESR, 32'h80);
        rd(OFF_ESR, 32'h0);
        rd(OFF_ESE, 32'h0);
        rd(OFF_STB, 32'h0);
        $display("test reset done");
        press();
        outs(3'b100);
        press();
        outs(3'b010);
        $display("test key done");
        ctl.pin(1'b1, 1'b0);
        outs(3'b100);
        ctl.send(MSG_LLO, 1'b1);
        rd(OFF_STATE, 32'h03);
        press();
        outs(3'b100);
        ctl.send(MSG_GTL, 1'b1);
        outs(3'b100);
        ctl.send(listenAddr, 1'b1);
        ctl.send(MSG_GTL, 1'b1);
        rd(OFF_STATE, 32'h06);
        ctl.send(MSG_UNL, 1'b1);
        ctl.pin(1'b0, 1'b0);
        rd(OFF_STATE, 32'h00);
        $display("test remote done");
        for (int i = 0; i < 4; i++) begin
            wr(OFF_CMD, 32'h1 << cb[i]);
            wr(OFF_CMD, 32'h1 << cb[i]);
            rd(OFF_ESR, 32'h1 << eb[i]);
            rd(OFF_ESR, 32'h0);
        end
        wr(OFF_ESE, 32'h20);
        wr(OFF_SRE, 32'h40);
        wr(OFF_CMD, 32'h1 << CMDB_CME);
        rd(OFF_STB, 32'h20);
        outs(3'b010);
        wr(OFF_SRE, 32'h20);
        repeat (2) @(posedge clk);
        rd(OFF_STB, 32'h60);
        outs(3'b011);
        $display("test events done");
        ctl.send(MSG_SPE, 1'b1);
        ctl.send(talkAddr, 1'b1);
        ctl.take(got);
        chk("poll byte", 32'h60, {24'h0, got});
        ctl.send(MSG_SPD, 1'b1);
        rd(OFF_ESR, 32'h20);
        repeat (2) @(posedge clk);
        outs(3'b010);
        rd(OFF_STB, 32'h0);
        $display("test poll done");
        opCondition <= 8'h05;
        repeat (2) @(posedge clk);
        rd(OFF_OPCOND, 32'h05);
        rd(OFF_OPEVT, 32'h05);
        opCondition <= 8'h00;
        repeat (2) @(posedge clk);
        rd(OFF_OPCOND, 32'h00);
        rd(OFF_OPEVT, 32'h05);
        wr(OFF_OPENA, 32'h01);
        rd(OFF_STB, 32'h80);
        wr(OFF_CMD, 32'h1 << CMDB_CLS);
        rd(OFF_OPEVT, 32'h00);
        rd(OFF_STB, 32'h00);
        $display("test condition done");
        ctl.sendText("*ESR?;*STB?");
        ctl.send(MSG_UNT, 1'b1);
        wr(OFF_RESP, 32'haa);
        wr(OFF_RESP, 32'hbb);
        repeat (2) @(posedge clk);
        tv(1'b0);
        ctl.send(talkAddr, 1'b1);
        ctl.take(got);
        chk("response", 32'hbb, {24'h0, got});
        wr(OFF_RESP, 32'hcc);
        repeat (2) @(posedge clk);
        tv(1'b1);
        ctl.pin(1'b0, 1'b1);
        tv(1'b0);
        ctl.pin(1'b0, 1'b0);
        ctl.send(talkAddr, 1'b1);
        wr(OFF_RESP, 32'hdd);
        repeat (2) @(posedge clk);
        ctl.send(MSG_SDC, 1'b1);
        tv(1'b1);
        ctl.send(MSG_DCL, 1'b1);
        tv(1'b0);
        $display("test talker done");
        apb(1'b0, 8'h3c, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        wr(OFF_STB, 32'hff);
        rd(OFF_STB, 32'h0);
        wr(OFF_ADDR, 32'h05);
        rd(OFF_ADDR, 32'h05);
        $display("test map done");
        summarize();
    end
endmodule
